// >>> hdl/iiec_top.sv
// iso in endpoint configuration byte and setup buffer behind an axi4-lite slave
// Functional notes
// RULE1 - bit 7 written one enables endpoint
// RULE2 - bit 6 selects isochronous or other transactions
// RULE3 - buffer manager overflow sets bit 5
// RULE4 - overflow clears only by software writing zero
// RULE5 - overflow flag never affects endpoint operation
// RULE6 - sample bytes equal field value plus one
// RULE7 - firmware programs full codec frame size
// RULE8 - setup packet stored in eight byte buffer
// RULE9 - request type lowest, length highest address
`timescale 1ns/1ps
`include "iiec_map.svh"
module iiec_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overflow_event,
  input wire logic setup_start,
  input wire logic setup_valid,
  input wire iiec_pkg::iiec_byte_t setup_data,
  output logic endpoint_enable,
  output logic iso_mode,
  output logic [5:0] sample_bytes
);
  import iiec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic w_strb0_r;
  logic w_have_r;
  logic bvalid_r;
  iiec_resp_t bresp_r;
  iiec_byte_t config_r;
  logic buffer_overrun_flag_r;
  logic [63:0] setup_packet;
  logic setup_done;
  logic wr_fire;
  logic wr_cfg;
  iiec_rd_state_t rd_state_r;
  logic [31:0] rdata_r;
  iiec_resp_t rresp_r;

  iiec_setup_buf #(.NBYTES(`IIEC_SETUP_BYTES)) u_setup (
    .aclk(aclk),
    .aresetn(aresetn),
    .setup_start(setup_start),
    .setup_valid(setup_valid),
    .setup_data(setup_data),
    .setup_packet(setup_packet),
    .setup_done(setup_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channels taken independently, response once both are held
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_cfg = wr_fire && (aw_addr_r == `IIEC_OFF_CONFIG) && w_strb0_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb0_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `IIEC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (aw_addr_r == `IIEC_OFF_CONFIG) ? `IIEC_RESP_OKAY : `IIEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration byte: software owned bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_r <= `IIEC_CONFIG_RST;
    end else if (wr_cfg) begin
      config_r[`IIEC_BIT_ENABLE] <= w_data_r[`IIEC_BIT_ENABLE]; // RULE1
      config_r[`IIEC_BIT_ISO] <= w_data_r[`IIEC_BIT_ISO]; // RULE2
      config_r[`IIEC_SBC_MSB:0] <= w_data_r[`IIEC_SBC_MSB:0]; // RULE6
      config_r[`IIEC_BIT_OVF] <= 1'b0;
    end
  end

  // set wins over a same-cycle clear; writing one leaves the flag alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_overrun_flag_r <= 1'b0;
    end else if (overflow_event) begin
      buffer_overrun_flag_r <= 1'b1; // RULE3
    end else if (wr_cfg && !w_data_r[`IIEC_BIT_OVF]) begin
      buffer_overrun_flag_r <= 1'b0; // RULE4
    end
  end

  // flag deliberately absent from every control output
  assign endpoint_enable = config_r[`IIEC_BIT_ENABLE]; // RULE1 RULE5
  assign iso_mode = config_r[`IIEC_BIT_ISO]; // RULE2
  // firmware is trusted to give the whole codec frame size here
  assign sample_bytes = {1'b0, config_r[`IIEC_SBC_MSB:0]} + 6'h01; // RULE6 RULE7

  ////////////////////////////////////////////////////////////////////////////
  // read path: one cycle to latch, then hold until rready
  assign s_axi_arready = (rd_state_r == IIEC_RD_IDLE);
  assign s_axi_rvalid = (rd_state_r == IIEC_RD_RESP);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= IIEC_RD_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `IIEC_RESP_OKAY;
    end else begin
      case (rd_state_r)
        IIEC_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_r <= IIEC_RD_RESP;
            rresp_r <= `IIEC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
              `IIEC_OFF_CONFIG: rdata_r <= {24'h000000, config_r[7:6],
                                            buffer_overrun_flag_r, config_r[4:0]};
              `IIEC_OFF_SETUP_LO: rdata_r <= setup_packet[31:0]; // RULE9
              `IIEC_OFF_SETUP_HI: rdata_r <= setup_packet[63:32]; // RULE9
              `IIEC_OFF_STATUS: rdata_r <= {31'h00000000, setup_done};
              default: begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= `IIEC_RESP_SLVERR;
              end
            endcase
          end
        end
        IIEC_RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_r <= IIEC_RD_IDLE;
          end
        end
        default: rd_state_r <= IIEC_RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_ovf_set;
    @(posedge aclk) disable iff (!aresetn)
      overflow_event |=> buffer_overrun_flag_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged"); // RULE3

  property p_ovf_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (buffer_overrun_flag_r && !(wr_cfg && !w_data_r[`IIEC_BIT_OVF])) |=> buffer_overrun_flag_r;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped"); // RULE4

  property p_ovf_clear;
    @(posedge aclk) disable iff (!aresetn)
      (wr_cfg && !w_data_r[`IIEC_BIT_OVF] && !overflow_event) |=> !buffer_overrun_flag_r;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared"); // RULE4

  property p_enable_wr;
    @(posedge aclk) disable iff (!aresetn)
      wr_cfg |=> endpoint_enable == $past(w_data_r[`IIEC_BIT_ENABLE]);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable not written"); // RULE1

  property p_iso_wr;
    @(posedge aclk) disable iff (!aresetn)
      wr_cfg |=> iso_mode == $past(w_data_r[`IIEC_BIT_ISO]);
  endproperty
  a_iso_wr: assert property (p_iso_wr) else $error("iso bit not written"); // RULE2

  property p_ovf_isolated;
    @(posedge aclk) disable iff (!aresetn)
      (overflow_event && !wr_cfg) |=> $stable(endpoint_enable) && $stable(iso_mode)
        && $stable(sample_bytes);
  endproperty
  a_ovf_isolated: assert property (p_ovf_isolated) else $error("flag changed control"); // RULE5

  property p_size;
    @(posedge aclk) disable iff (!aresetn)
      sample_bytes == config_r[`IIEC_SBC_MSB:0] + 6'h01;
  endproperty
  a_size: assert property (p_size) else $error("sample size wrong"); // RULE6

  sequence s_setup_first;
    setup_start ##1 (setup_valid && !setup_start);
  endsequence
  property p_setup_lowest;
    @(posedge aclk) disable iff (!aresetn)
      s_setup_first |=> setup_packet[7:0] == $past(setup_data);
  endproperty
  a_setup_lowest: assert property (p_setup_lowest) else $error("request type misplaced"); // RULE9

  property p_read_resp;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("read answer late");
endmodule // iiec_top

// >>> pkg/iiec_map.svh
// register offsets, field positions and reset values for the iso in endpoint block
`ifndef IIEC_MAP_SVH
`define IIEC_MAP_SVH
`define IIEC_OFF_CONFIG 8'h00
`define IIEC_OFF_SETUP_LO 8'h04
`define IIEC_OFF_SETUP_HI 8'h08
`define IIEC_OFF_STATUS 8'h0C
`define IIEC_BIT_ENABLE 7
`define IIEC_BIT_ISO 6
`define IIEC_BIT_OVF 5
`define IIEC_SBC_MSB 4
`define IIEC_CONFIG_RST 8'h00
`define IIEC_SETUP_BYTES 8
`define IIEC_RESP_OKAY 2'b00
`define IIEC_RESP_SLVERR 2'b10
`endif

// >>> pkg/iiec_pkg.sv
// types shared by the iso in endpoint configuration block
package iiec_pkg;
  typedef logic [7:0] iiec_byte_t;
  typedef logic [1:0] iiec_resp_t;
  typedef enum logic [2:0] {
    IIEC_RD_IDLE = 3'b001,
    IIEC_RD_WAIT = 3'b010,
    IIEC_RD_RESP = 3'b100
  } iiec_rd_state_t;
endpackage

// >>> hdl/iiec_setup_buf.sv
// eight byte setup packet buffer, one byte per beat at rising addresses
`timescale 1ns/1ps
`include "iiec_map.svh"
module iiec_setup_buf #(
  parameter int NBYTES = `IIEC_SETUP_BYTES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic setup_start,
  input wire logic setup_valid,
  input wire iiec_pkg::iiec_byte_t setup_data,
  output logic [8*NBYTES-1:0] setup_packet,
  output logic setup_done
);
  import iiec_pkg::*;
  logic [3:0] idx_r;
  logic [8*NBYTES-1:0] buf_r;
  logic done_r;
  assign setup_packet = buf_r;
  assign setup_done = done_r;
  // byte 0 (request type) at the lowest address, length high byte on top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r <= 4'h0;
      done_r <= 1'b0;
      buf_r <= '0;
    end else if (setup_start) begin
      idx_r <= 4'h0;
      done_r <= 1'b0;
    end else if (setup_valid && idx_r < 4'(NBYTES)) begin
      buf_r[idx_r*8 +: 8] <= setup_data; // RULE8 RULE9
      idx_r <= idx_r + 4'h1;
      done_r <= (idx_r == 4'(NBYTES - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_setup_full;
    @(posedge aclk) disable iff (!aresetn)
      (setup_valid && !setup_start && idx_r == 4'(NBYTES - 1)) |=> setup_done;
  endproperty
  a_setup_full: assert property (p_setup_full) else $error("setup packet not complete"); // RULE8

  // bytes past the eighth must not disturb a captured packet
  property p_setup_frozen;
    @(posedge aclk) disable iff (!aresetn)
      (setup_done && setup_valid && !setup_start) |=> $stable(setup_packet);
  endproperty
  a_setup_frozen: assert property (p_setup_frozen) else $error("setup packet overwritten"); // RULE8
endmodule // iiec_setup_buf

// >>> verification/iiec_host_model.sv
// behavioural usb host that streams one setup packet into the buffer
`timescale 1ns/1ps
module iiec_host_model (
  input wire logic aclk,
  input wire logic send,
  input wire logic slow,
  input wire logic [63:0] packet,
  output logic setup_start,
  output logic setup_valid,
  output iiec_pkg::iiec_byte_t setup_data,
  output logic busy
);
  import iiec_pkg::*;
  initial begin
    setup_start = 1'b0;
    setup_valid = 1'b0;
    setup_data = 8'h00;
    busy = 1'b0;
  end
  always begin
    @(posedge aclk);
    if (send && !busy) begin
      busy <= 1'b1;
      setup_start <= 1'b1;
      @(posedge aclk);
      setup_start <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        setup_valid <= 1'b1;
        setup_data <= packet[8*i +: 8];
        @(posedge aclk);
        if (slow) begin
          // between bytes the lines wander so stale data is never mistaken for valid
          setup_valid <= 1'b0;
          setup_data <= ~setup_data;
          @(posedge aclk);
        end
      end
      setup_valid <= 1'b0;
      setup_data <= ~setup_data;
      busy <= 1'b0;
    end
  end
endmodule // iiec_host_model

// >>> verification/testbench.sv
// self-checking bench for the iso in endpoint configuration block
`timescale 1ns/1ps
module testbench;
  import iiec_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ovf_ev = 1'b0, send = 1'b0, slow = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic [63:0] pkt = 64'h0000000000000000;
  logic awready, wready, bvalid, arready, rvalid, sst, svl, busy, en, iso;
  logic [1:0] bresp, rresp, rs, bs;
  logic [31:0] rdata, rd;
  iiec_byte_t sdat;
  logic [5:0] sb;
  int error_cnt = 0;
  int tests_run = 0;

  always #12.5 aclk = ~aclk;

  iiec_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .overflow_event(ovf_ev), .setup_start(sst),
    .setup_valid(svl), .setup_data(sdat), .endpoint_enable(en), .iso_mode(iso),
    .sample_bytes(sb));

  iiec_host_model u_host (.aclk(aclk), .send(send), .slow(slow), .packet(pkt),
    .setup_start(sst), .setup_valid(svl), .setup_data(sdat), .busy(busy));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic pkt_run(input logic [63:0] p, input logic s);
    @(posedge aclk);
    pkt <= p;
    slow <= s;
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    do @(posedge aclk); while (busy !== 1'b0);
    rdr(8'h04);
    chk("setup low word", p[31:0], rd);
    rdr(8'h08);
    chk("setup high word", p[63:32], rd);
    rdr(8'h0C);
    chk("setup done", 32'h00000001, rd);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h00);
    chk("config reset", 32'h00000000, rd);
    chk("sample bytes reset", 32'h00000001, {26'h0, sb});
    wr(8'h00, 32'h000000FF);
    chk("config write resp", 32'h00000000, {30'h0, bs});
    rdr(8'h00);
    chk("config all set", 32'h000000DF, rd);
    chk("enable", 32'h00000001, {31'h0, en});
    chk("iso mode", 32'h00000001, {31'h0, iso});
    chk("sample bytes max", 32'h00000020, {26'h0, sb});
    // a four channel 16-bit frame is eight bytes
    wr(8'h00, 32'h00000007);
    chk("enable off", 32'h00000000, {31'h0, en});
    chk("iso off", 32'h00000000, {31'h0, iso});
    chk("sample bytes frame", 32'h00000008, {26'h0, sb});
    wr(8'h00, 32'h000000C7);
    @(posedge aclk);
    ovf_ev <= 1'b1;
    @(posedge aclk);
    ovf_ev <= 1'b0;
    rdr(8'h00);
    chk("overflow set", 32'h000000E7, rd);
    chk("enable kept", 32'h00000001, {31'h0, en});
    chk("iso kept", 32'h00000001, {31'h0, iso});
    chk("sample kept", 32'h00000008, {26'h0, sb});
    wr(8'h00, 32'h000000E7);
    rdr(8'h00);
    chk("overflow held", 32'h000000E7, rd);
    wr(8'h00, 32'h000000C7);
    rdr(8'h00);
    chk("overflow cleared", 32'h000000C7, rd);
    pkt_run(64'h0012000001000680, 1'b1);
    wr(8'h00, 32'h00000000);
    pkt_run(64'h0040000002000921, 1'b0);
    rdr(8'h10);
    chk("unmapped data", 32'h00000000, rd);
    chk("unmapped resp", 32'h00000002, {30'h0, rs});
    wr(8'h10, 32'h00000000);
    chk("unmapped write resp", 32'h00000002, {30'h0, bs});
    // a write without the low byte lane leaves the configuration alone
    wstrb <= 4'hE;
    wr(8'h00, 32'h000000FF);
    wstrb <= 4'hF;
    chk("masked write resp", 32'h00000000, {30'h0, bs});
    rdr(8'h00);
    chk("masked write ignored", 32'h00000000, rd);
    give_verdict();
  end

  initial begin
    repeat (4000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
endmodule // testbench
